// ---- cdp_bank.sv ----
`include "cdp_defines.svh"

module cdp_bank
  import cdp_pkg::*;
(
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  input  wire logic                       tx_en,
  input  wire logic                       cfg_wr,
  input  wire logic                       cfg_rd,
  input  wire logic [`CDP_ADDR_W-1:0]     cfg_addr,
  input  wire logic [`CDP_PROFILE_W-1:0]  cfg_wdata,
  output logic [`CDP_PROFILE_W-1:0]       cfg_rdata,
  output logic [`CDP_NUM_CH-1:0]          drive_p,
  output logic [`CDP_NUM_CH-1:0]          drive_n,
  output logic                            fire_busy
);

  localparam int NCH = `CDP_NUM_CH;

  logic [1:0]     rst_sync_reg;
  logic           rst_n;
  cdp_top_t       s_reg;
  cdp_top_t       s_next;
  logic           internal_clock_en;
  logic [NCH-1:0] ch_busy;
  logic           busy_next;
  logic           busy_reg;
  logic           hit;
  logic [2:0]     idx;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Reset image of the profile registers
  function automatic cdp_profile_t rst_prof(input int k);
    cdp_profile_t p;
    p        = '0;
    p.coarse = `CDP_COARSE_W'(k * `CDP_RST_COARSE_STEP);
    p.fine   = 3'(k);
    return p;
  endfunction

  function automatic cdp_top_t rst_state();
    cdp_top_t t;
    t = '0;
    for (int k = 0; k < NCH; k++) begin
      t.prof[k] = rst_prof(k);
    end
    return t;
  endfunction

  // Folded to a constant so the asynchronous reset loads fixed values only
  localparam cdp_top_t RST_STATE = rst_state();

  ////////////////////////////////////////////////////////////////////////////
  // Address decode for the profile window
  always_comb begin
    hit = 1'b0;
    idx = 3'h0;
    if (cfg_addr >= `CDP_OFS_CH_FIRST && cfg_addr <= `CDP_OFS_CH_LAST) begin
      hit = 1'b1;
      idx = cfg_addr[2:0];
    end else begin
      hit = 1'b0;
    end
  end

  // Internal clock enable: one ref_clk tick in eight is an internal edge
  assign internal_clock_en = s_reg.div == 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the bank
  always_comb begin
    s_next = s_reg;
    // Three stage pin sampling; the first stage feeds only the second
    s_next.tx_sync = {s_reg.tx_sync[1:0], tx_en};
    s_next.fire    = 1'b0;
    if (s_reg.tx_sync[1] == s_reg.tx_sync[2]) begin
      s_next.tx_filt = s_reg.tx_sync[2];
      // One common fire event for every channel on the rising edge
      s_next.fire = s_reg.tx_sync[2] && !s_reg.tx_filt;
    end
    // Divider is re-phased by the fire so the coarse grid starts with it
    if (s_reg.fire) begin
      s_next.div = 3'h0;
    end else begin
      s_next.div = s_reg.div + 3'h1;
    end
    // Register writes; unmapped offsets are ignored
    if (cfg_wr && hit) begin
      s_next.prof[idx] = cdp_profile_t'(cfg_wdata);
    end
    // Reads return the profile word, zero outside the window
    if (cfg_rd) begin
      if (hit) begin
        s_next.rdata = s_reg.prof[idx];
      end else begin
        s_next.rdata = '0;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= RST_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One delay unit per channel, each reading only its own profile
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    cdp_channel u_ch (
      .clk     (ref_clk),
      .rst_n   (rst_n),
      .fire    (s_reg.fire),
      .internal_clock_en (internal_clock_en),
      .prof    (s_reg.prof[c]),
      .p_out   (drive_p[c]),
      .n_out   (drive_n[c]),
      .busy    (ch_busy[c])
    );
  end

  // Busy flag registered so the port comes from a flop
  assign busy_next = |ch_busy;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
    end
  end

  assign cfg_rdata = s_reg.rdata;
  assign fire_busy = busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_reg_write: assert property (cfg_wr && hit
      |=> s_reg.prof[$past(idx)] == $past(cfg_wdata))
    else $error("profile write not stored at its offset");
  a_reg_read: assert property (cfg_rd && !cfg_wr
      |=> cfg_rdata == ($past(hit) ? $past(s_reg.prof[idx]) : '0))
    else $error("profile read returned wrong word");
  a_common_fire: assert property (s_reg.fire && !(|ch_busy)
      |=> &ch_busy ##1 fire_busy)
    else $error("channels did not start on the common fire");
  a_fire_regrid: assert property (s_reg.fire
      |=> s_reg.div == 3'h0 ##7 internal_clock_en)
    else $error("internal clock grid not aligned to fire");

endmodule

// ---- cdp_defines.svh ----
`ifndef CDP_DEFINES_SVH
`define CDP_DEFINES_SVH

// Register map: one profile word per channel at offsets 0x00..0x07
`define CDP_ADDR_W         5
`define CDP_NUM_CH         8
`define CDP_PROFILE_W      22
`define CDP_OFS_CH_FIRST   5'h00
`define CDP_OFS_CH_LAST    5'h07

// Field positions inside a profile word
`define CDP_ADJ_EN_MSB     21
`define CDP_ADJ_EN_LSB     20
`define CDP_ADJ_PH_MSB     19
`define CDP_ADJ_PH_LSB     17
`define CDP_COARSE_MSB     16
`define CDP_COARSE_LSB     3
`define CDP_FINE_MSB       2
`define CDP_FINE_LSB       0
`define CDP_COARSE_W       14

// Width adjust enable codes
`define CDP_ADJ_OFF_LO     2'b00
`define CDP_ADJ_NEG        2'b01
`define CDP_ADJ_POS        2'b10
`define CDP_ADJ_OFF_HI     2'b11

// Reset profile of channel k: coarse = k * step, fine = k
`define CDP_RST_COARSE_STEP 2

// Timing: ref_clk period, eight phase steps per internal clock cycle
`define CDP_REF_PERIOD_NS  40
`define CDP_PHASES         8
`define CDP_INTERNAL_CLOCK_PERIOD_NS (`CDP_REF_PERIOD_NS * `CDP_PHASES)
// Each unadjusted drive output is held one internal clock cycle, positive first
`define CDP_HALF_TICKS     4'h8
`define CDP_PULSE_LAST     4'hf
// Ticks from the tx_en sampling edge to the first drive output edge
`define CDP_PROP_TICKS     6

`endif

// ---- cdp_pkg.sv ----
`include "cdp_defines.svh"

package cdp_pkg;

  // One channel delay profile word
  typedef struct packed {
    logic [1:0]                adj_en;
    logic [2:0]                adj_phase;
    logic [`CDP_COARSE_W-1:0]  coarse;
    logic [2:0]                fine;
  } cdp_profile_t;

  typedef enum logic [3:0] {
    CDP_IDLE   = 4'b0001,
    CDP_COARSE = 4'b0010,
    CDP_FINE   = 4'b0100,
    CDP_PULSE  = 4'b1000
  } cdp_ch_state_t;

  // Complete state of one channel delay unit
  typedef struct packed {
    cdp_ch_state_t             st;
    cdp_profile_t              snap;
    logic [`CDP_COARSE_W-1:0]  cnt;
    logic [3:0]                tcnt;
    logic                      p;
    logic                      n;
  } cdp_ch_t;

  // Complete state of the bank (reset synchroniser and busy_reg kept apart)
  typedef struct packed {
    logic [2:0]                          tx_sync;
    logic                                tx_filt;
    logic                                fire;
    logic [2:0]                          div;
    cdp_profile_t [`CDP_NUM_CH-1:0]      prof;
    logic [`CDP_PROFILE_W-1:0]           rdata;
  } cdp_top_t;

endpackage

// ---- cdp_channel.sv ----
`include "cdp_defines.svh"

module cdp_channel
  import cdp_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         fire,
  input  wire logic         internal_clock_en,
  input  wire cdp_profile_t prof,
  output logic              p_out,
  output logic              n_out,
  output logic              busy
);

  cdp_ch_t s_reg;
  cdp_ch_t s_next;
  logic    p_ok;
  logic    n_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: coarse count on internal clock, fine count on phase ticks
  always_comb begin
    s_next = s_reg;
    p_ok   = 1'b0;
    n_ok   = 1'b0;
    case (s_reg.st)
      CDP_IDLE: begin
        // Snapshot so a write during a firing cannot bend this shot
        if (fire) begin
          s_next.snap = prof;
          if (prof.coarse == '0) begin
            s_next.st  = CDP_FINE;
            s_next.cnt = {11'h000, prof.fine};
          end else begin
            s_next.st  = CDP_COARSE;
            s_next.cnt = prof.coarse;
          end
        end
      end
      CDP_COARSE: begin
        if (internal_clock_en) begin
          if (s_reg.cnt == 14'h0001) begin
            s_next.st  = CDP_FINE;
            s_next.cnt = {11'h000, s_reg.snap.fine};
          end else begin
            s_next.cnt = s_reg.cnt - 14'h0001;
          end
        end
      end
      CDP_FINE: begin
        // Each fine code step is one eighth of an internal cycle
        if (s_reg.cnt == '0) begin
          s_next.st   = CDP_PULSE;
          s_next.tcnt = 4'h0;
        end else begin
          s_next.cnt = s_reg.cnt - 14'h0001;
        end
      end
      CDP_PULSE: begin
        // Positive half first, then negative half
        p_ok = s_reg.tcnt < `CDP_HALF_TICKS;
        n_ok = s_reg.tcnt >= `CDP_HALF_TICKS;
        case (s_reg.snap.adj_en)
          `CDP_ADJ_POS: p_ok = p_ok &&
              (s_reg.tcnt >= {1'b0, s_reg.snap.adj_phase});
          `CDP_ADJ_NEG: n_ok = n_ok &&
              (s_reg.tcnt >= (`CDP_HALF_TICKS +
                              {1'b0, s_reg.snap.adj_phase}));
          default: ;
        endcase
        if (s_reg.tcnt == `CDP_PULSE_LAST) begin
          s_next.st = CDP_IDLE;
        end else begin
          s_next.tcnt = s_reg.tcnt + 4'h1;
        end
      end
      default: s_next.st = CDP_IDLE;
    endcase
    // Shared register stage for both outputs keeps them phase aligned
    s_next.p = p_ok;
    s_next.n = n_ok && !p_ok;
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{st: CDP_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign p_out = s_reg.p;
  assign n_out = s_reg.n;
  assign busy  = s_reg.st != CDP_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_fire_idle;
    fire && s_reg.st == CDP_IDLE;
  endsequence
  sequence s_coarse_done;
    s_reg.st == CDP_COARSE && internal_clock_en && s_reg.cnt == 14'h0001;
  endsequence
  sequence s_fine_step;
    s_reg.st == CDP_FINE && s_reg.cnt != '0;
  endsequence

  a_no_overlap: assert property (!(p_out && n_out))
    else $error("positive and negative outputs overlap");
  a_coarse_load: assert property (s_fire_idle and prof.coarse != '0
      |=> s_reg.st == CDP_COARSE && s_reg.cnt == $past(prof.coarse))
    else $error("coarse count not loaded at fire");
  a_coarse_end: assert property (s_coarse_done
      |=> s_reg.st == CDP_FINE && s_reg.cnt[2:0] == s_reg.snap.fine)
    else $error("coarse count did not hand over to fine");
  a_fine_steps: assert property (s_fire_idle and prof.coarse == '0
      |=> s_reg.st == CDP_FINE && s_reg.cnt == $past(prof.fine)
          ##[1:8] s_reg.st == CDP_PULSE && s_reg.tcnt == 4'h0)
    else $error("fine delay not taken in phase ticks");
  a_fine_count: assert property (s_fine_step
      |=> s_reg.st == CDP_FINE && s_reg.cnt == $past(s_reg.cnt) - 14'h0001)
    else $error("fine count did not step by one tick");
  a_same_phase: assert property ($rose(p_out) && (s_reg.snap.adj_en ==
      `CDP_ADJ_OFF_LO || s_reg.snap.adj_en == `CDP_ADJ_OFF_HI)
      |-> $past(s_reg.tcnt) == 4'h0 ##8 $fell(p_out) && $rose(n_out))
    else $error("unadjusted pair not latched on one phase");
  a_neg_lag: assert property ($rose(n_out) &&
      s_reg.snap.adj_en == `CDP_ADJ_NEG
      |-> $past(s_reg.tcnt) == `CDP_HALF_TICKS + s_reg.snap.adj_phase)
    else $error("negative output lag wrong");
  a_pos_lag: assert property ($rose(p_out) &&
      s_reg.snap.adj_en == `CDP_ADJ_POS
      |-> $past(s_reg.tcnt) == {1'b0, s_reg.snap.adj_phase})
    else $error("positive output lag wrong");

endmodule

// ---- cdp_pulser_model.sv ----
`include "cdp_defines.svh"

// Receiving side of the high voltage pulser: logs drive edges per channel
module cdp_pulser_model
  import cdp_pkg::*;
(
  input wire logic                    ref_clk,
  input wire logic [`CDP_NUM_CH-1:0]  drive_p,
  input wire logic [`CDP_NUM_CH-1:0]  drive_n
);
  timeunit 1ns;
  timeprecision 1ps;

  int                    cyc = 0;
  int                    overlap_count = 0;
  int                    p_rise [`CDP_NUM_CH];
  int                    p_fall [`CDP_NUM_CH];
  int                    n_rise [`CDP_NUM_CH];
  int                    n_fall [`CDP_NUM_CH];
  logic [`CDP_NUM_CH-1:0] p_prev = '0;
  logic [`CDP_NUM_CH-1:0] n_prev = '0;

  ////////////////////////////////////////////////////////////////////////////
  // Edge count; read on the falling edge so it never races the drives
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
  end

  // A shorted bridge in the pulser would follow any overlap, so log it
  always @(negedge ref_clk) begin
    for (int k = 0; k < `CDP_NUM_CH; k++) begin
      if (drive_p[k] && !p_prev[k]) p_rise[k] = cyc;
      if (!drive_p[k] && p_prev[k]) p_fall[k] = cyc;
      if (drive_n[k] && !n_prev[k]) n_rise[k] = cyc;
      if (!drive_n[k] && n_prev[k]) n_fall[k] = cyc;
      if (drive_p[k] && drive_n[k]) overlap_count++;
    end
    p_prev = drive_p;
    n_prev = drive_n;
  end
endmodule

// ---- channel_delay_profile_bank_tb_top.sv ----
`include "cdp_defines.svh"

`define CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("BAD %0t got %0h exp %0h", $time, got, exp); \
  end \
end

module channel_delay_profile_bank_tb_top
  import cdp_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  logic                       ref_clk = 1'b0;
  logic                       nrst = 1'b0;
  logic                       tx_en = 1'b0;
  logic                       cfg_wr = 1'b0;
  logic                       cfg_rd = 1'b0;
  logic [`CDP_ADDR_W-1:0]     cfg_addr = '0;
  logic [`CDP_PROFILE_W-1:0]  cfg_wdata = '0;
  logic [`CDP_PROFILE_W-1:0]  cfg_rdata;
  logic [`CDP_NUM_CH-1:0]     drive_p;
  logic [`CDP_NUM_CH-1:0]     drive_n;
  logic                       fire_busy;
  int                         err_count = 0;
  int                         cmp_count = 0;
  int                         seed = 38;
  int                         m_en [8];
  int                         m_ph [8];
  int                         m_co [8];
  int                         m_fi [8];

  cdp_bank cdp_bank_inst (.ref_clk, .nrst, .tx_en, .cfg_wr, .cfg_rd,
    .cfg_addr, .cfg_wdata, .cfg_rdata, .drive_p, .drive_n, .fire_busy);

  cdp_pulser_model cdp_pulser_model_inst (.ref_clk, .drive_p, .drive_n);

  always #20 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or the watchdog
  task automatic stop_test();
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  // Reset image of the model: channel k has coarse 2k and fine k
  task automatic model_defaults();
    for (int k = 0; k < 8; k++) begin
      m_en[k] = 0;
      m_ph[k] = 0;
      m_co[k] = `CDP_RST_COARSE_STEP * k;
      m_fi[k] = k;
    end
  endtask

  // Strobe is dropped for a full cycle so two calls never collide
  task automatic reg_wr(input logic [4:0] a, input logic [21:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    tick();
    cfg_wr = 1'b0;
    tick();
    if (a < 8) begin
      m_en[a] = d[21:20];
      m_ph[a] = d[19:17];
      m_co[a] = d[16:3];
      m_fi[a] = d[2:0];
    end
  endtask

  task automatic reg_chk(input logic [4:0] a);
    logic [21:0] exp;
    exp = '0;
    if (a < 8)
      exp = {m_en[a][1:0], m_ph[a][2:0], m_co[a][13:0], m_fi[a][2:0]};
    cfg_rd = 1'b1;
    cfg_addr = a;
    tick();
    cfg_rd = 1'b0;
    tick();
    `CHK(cfg_rdata, exp)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One shot on all channels, then every edge time checked against model
  task automatic shot();
    int e0;
    int b;
    int n;
    int pl;
    int nl;
    tx_en = 1'b1;
    e0 = cdp_pulser_model_inst.cyc + 1;
    n = 0;
    while (fire_busy !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    `CHK(fire_busy, 1'b1)
    n = 0;
    while (fire_busy !== 1'b0 && n < 70000) begin
      tick();
      n++;
    end
    tx_en = 1'b0;
    repeat (4) tick();
    for (int k = 0; k < 8; k++) begin
      b = e0 + `CDP_PROP_TICKS + 8 * m_co[k] + m_fi[k];
      pl = (m_en[k] == 2) ? m_ph[k] : 0;
      nl = (m_en[k] == 1) ? m_ph[k] : 0;
      `CHK(cdp_pulser_model_inst.p_rise[k], b + pl)
      `CHK(cdp_pulser_model_inst.p_fall[k], b + 8)
      `CHK(cdp_pulser_model_inst.n_rise[k], b + 8 + nl)
      `CHK(cdp_pulser_model_inst.n_fall[k], b + 16)
    end
    `CHK(cdp_pulser_model_inst.overlap_count, 0)
  endtask

  // Longest shot is about 66000 cycles, so this leaves ample margin
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: defaults, random profiles per enable code, long coarse
  initial begin
    logic [21:0] d;
    model_defaults();
    repeat (5) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    repeat (3) tick();
    for (int k = 0; k < 8; k++) reg_chk(5'(k));
    reg_chk(5'h1f);
    shot();
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 8; k++) begin
        d = 22'($random(seed));
        d[16:7] = '0;
        d[21:20] = 2'((k + r) % 4);
        reg_wr(5'(k), d);
      end
      reg_wr(5'h08, 22'($random(seed)));
      reg_chk(5'h08);
      for (int k = 0; k < 8; k++) reg_chk(5'(k));
      shot();
    end
    // Reset in mid-run: profiles and the read word fall back to defaults
    nrst = 1'b0;
    tick();
    `CHK(cfg_rdata, 22'h00_0000)
    `CHK(drive_p | drive_n, 8'h00)
    nrst = 1'b1;
    model_defaults();
    repeat (3) tick();
    for (int k = 0; k < 8; k++) reg_chk(5'(k));
    // Top coarse bit in use: exercises the full counter width
    reg_wr(5'h00, 22'h2f_000d);
    reg_chk(5'h00);
    shot();
    stop_test();
  end
endmodule
